// File: inc/cpm_pkg.sv
// management-side register layout, field positions and timing of the copper transceiver
// assumes a single 250 MHz clock; no bus, requests arrive as cpm_req_s words
package cpm_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SOFT_RESET_NS = 100;
  localparam int SOFT_RESET_CYC = (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ----------------------------------------
  // pages and register addresses
  // ----------------------------------------
  localparam logic [1:0] PAGE_STD = 2'h0;
  localparam logic [1:0] PAGE_EXT1 = 2'h1;
  localparam logic [1:0] PAGE_EXT2 = 2'h2;
  localparam logic [1:0] PAGE_GP = 2'h3;
  localparam logic [4:0] PAGED_LO = 5'h10;
  localparam logic [4:0] PAGED_HI = 5'h1E;
  localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REG_MMD_CTRL = 5'h0D;
  localparam logic [4:0] REG_MMD_DATA = 5'h0E;
  localparam logic [4:0] REG_BYPASS = 5'h12;
  localparam logic [4:0] REG_EXT_CTRL3 = 5'h14;
  localparam logic [4:0] REG_EXT_CTRL_STAT = 5'h16;
  localparam logic [4:0] REG_EXT_MODE = 5'h17;
  localparam logic [4:0] REG_AUX_STAT = 5'h1C;
  localparam logic [4:0] REG_PAGE_SEL = 5'h1F;
  localparam logic [4:0] REG_ENERGY_CTRL = 5'h11;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BC_SOFT_RESET = 15;
  localparam int BC_SPEED_LSB = 13;
  localparam int BC_NEG_EN = 12;
  localparam int BC_DUPLEX = 8;
  localparam int BC_SPEED_MSB = 6;
  localparam int BY_FSPD_XOVER_DIS = 7;
  localparam int BY_PAIR_SWAP_DISABLE = 5;
  localparam int BY_POL_CORR_DIS = 4;
  localparam int E3_DS_EN = 4;
  localparam int E3_DS_CNT = 2;
  localparam int E3_DS_STAT = 1;
  localparam int ECS_ALL_ADDR_WR = 13;
  localparam int ECS_RETAIN_CTRL = 12;
  localparam int EM_XOVER_SEL = 2;
  localparam int AUX_XOVER = 13;
  localparam int AUX_SWAP = 12;
  localparam int AUX_POL = 8;
  localparam int EN_FGIG_TEST = 15;
  localparam int MMD_FUNC = 14;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] BASIC_CTRL_RST = 16'h1140;
  localparam logic [15:0] BYPASS_RST = 16'h0000;
  localparam logic [15:0] EXT_CTRL3_RST = 16'h0000;
  localparam logic [15:0] EXT_CTRL_STAT_RST = 16'h1000;
  localparam logic [15:0] EXT_MODE_RST = 16'h0000;
  localparam logic [15:0] ENERGY_CTRL_RST = 16'h0000;
  localparam logic [15:0] MMD_RST = 16'h0000;
  localparam logic [2:0] DS_BASE_ATTEMPTS = 3'h2;
  // ----------------------------------------
  // writable bits; read-only and reserved bits stay zero
  // ----------------------------------------
  localparam logic [15:0] BASIC_CTRL_MASK = 16'h3140;
  localparam logic [15:0] ECS_MASK = 16'h3000;
  localparam logic [15:0] EXT_MODE_MASK = 16'h000C;
  localparam logic [15:0] ENERGY_MASK = 16'h8000;
  localparam logic [15:0] BYPASS_MASK = 16'h00B0;
  localparam logic [15:0] EXT_CTRL3_MASK = 16'h001C;
  // ----------------------------------------
  // encodings and carriers
  // ----------------------------------------
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] XSEL_STRAIGHT = 2'h2;
  localparam logic [1:0] XSEL_CROSSED = 2'h3;
  localparam logic [1:0] MAP_STRAIGHT = 2'h0;
  localparam logic [1:0] MAP_CROSSED = 2'h1;
  typedef enum logic {CPM_RUN, CPM_SOFT_RESET} cpm_state_e;
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } cpm_req_s;
  typedef struct packed {
    logic partner_neg;
    logic [1:0] neg_speed;
    logic neg_full_duplex;
    logic [1:0] par_speed;
    logic [1:0] det_map;
    logic [3:0] pol_inverted;
    logic gig_attempt_fail;
    logic gig_partner_seen;
  } cpm_link_s;
endpackage

// File: src/cpm_reg_mem.sv
// storage for the unmodelled paged, general-purpose and clause 45 words
// assumes one clock; clear wipes every word in one edge
`timescale 1ns/10ps
module cpm_reg_mem (
  input wire logic clk_in,
  input wire logic clear_in,
  input wire logic wr_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  // flops, not a macro: both resets must empty it at once
  logic [15:0] mem_q [256];

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 256; i++) begin
      if (clear_in) begin
        mem_q[i] <= 16'h0000;
      end else if (wr_in && addr_in == 8'(i)) begin
        mem_q[i] <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (clear_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= mem_q[addr_in];
    end
  end
endmodule // cpm_reg_mem

// File: src/cpm_mgmt_cfg.sv
// management register bank and mode control of one copper transceiver
// assumes synchronous requests, one per cycle at most, and a link engine feeding LINK_IN
`timescale 1ns/10ps
module cpm_mgmt_cfg (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [4:0] PHY_ADDR_IN,
  input wire cpm_pkg::cpm_req_s REQ_IN,
  input wire cpm_pkg::cpm_link_s LINK_IN,
  output logic RVALID_OUT,
  output logic [15:0] RDATA_OUT,
  output logic [1:0] SPEED_OUT,
  output logic FULL_DUPLEX_OUT,
  output logic ADVERTISE_GIG_OUT,
  output logic [1:0] MDI_MAP_OUT,
  output logic [3:0] POL_FIX_OUT
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // paged spaces only cover 16..30 (general-purpose 0..30); the rest falls to standard
  function automatic logic [1:0] eff_page(input logic [1:0] pg, input logic [4:0] ra);
    if (ra == cpm_pkg::REG_PAGE_SEL) begin
      eff_page = cpm_pkg::PAGE_STD;
    end else if (pg == cpm_pkg::PAGE_GP) begin
      eff_page = pg;
    end else if (ra < cpm_pkg::PAGED_LO || ra > cpm_pkg::PAGED_HI) begin
      eff_page = cpm_pkg::PAGE_STD;
    end else begin
      eff_page = pg;
    end
  endfunction

  function automatic logic is_std(input logic [1:0] ep, input logic [4:0] ra,
                                  input logic [4:0] want);
    is_std = (ep == cpm_pkg::PAGE_STD) && (ra == want);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  cpm_pkg::cpm_state_e state_q, state_d;
  logic [7:0] srst_cnt_q;
  logic [15:0] ctrl_q, bypass_q, ext3_q, ecs_q, emode_q, energy_q, mmd_ctl_q, mmd_adr_q;
  logic [1:0] page_q;
  logic [2:0] fail_cnt_q;
  logic down_q;
  logic rvalid_q, mem_sel_q;
  logic [15:0] reg_rdata_q;
  logic [15:0] mem_rdata;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  wire in_srst = (state_q == cpm_pkg::CPM_SOFT_RESET);
  wire addr_match = (REQ_IN.phy_addr == PHY_ADDR_IN);
  wire wr_ok = REQ_IN.valid && REQ_IN.write && !in_srst &&
               (addr_match || ecs_q[cpm_pkg::ECS_ALL_ADDR_WR]);
  wire rd_ok = REQ_IN.valid && !REQ_IN.write && addr_match;
  wire [4:0] ra = REQ_IN.reg_addr;
  wire [1:0] ep = eff_page(page_q, ra);
  wire hit_ctrl = is_std(ep, ra, cpm_pkg::REG_BASIC_CTRL);
  wire hit_mctl = is_std(ep, ra, cpm_pkg::REG_MMD_CTRL);
  wire hit_mdat = is_std(ep, ra, cpm_pkg::REG_MMD_DATA);
  wire hit_byp = is_std(ep, ra, cpm_pkg::REG_BYPASS);
  wire hit_ext3 = is_std(ep, ra, cpm_pkg::REG_EXT_CTRL3);
  wire hit_ecs = is_std(ep, ra, cpm_pkg::REG_EXT_CTRL_STAT);
  wire hit_emode = is_std(ep, ra, cpm_pkg::REG_EXT_MODE);
  wire hit_aux = is_std(ep, ra, cpm_pkg::REG_AUX_STAT);
  wire hit_page = (ra == cpm_pkg::REG_PAGE_SEL);
  wire hit_energy = (ep == cpm_pkg::PAGE_EXT2) && (ra == cpm_pkg::REG_ENERGY_CTRL);
  wire mmd_addr_fn = (mmd_ctl_q[15:cpm_pkg::MMD_FUNC] == 2'h0);
  wire hit_model = hit_ctrl | hit_mctl | hit_byp | hit_ext3 | hit_ecs | hit_emode |
                   hit_aux | hit_page | hit_energy | (hit_mdat & mmd_addr_fn);
  // clause 45 words live only behind 13/14, in the upper half of the store
  wire [7:0] mem_addr = (hit_mdat && !mmd_addr_fn) ?
                        {1'b1, mmd_ctl_q[2:0], mmd_adr_q[3:0]} : {1'b0, ep, ra};
  wire mem_wr = wr_ok && !hit_model;
  wire srst_start = wr_ok && hit_ctrl && REQ_IN.wdata[cpm_pkg::BC_SOFT_RESET];
  wire srst_done = in_srst && (srst_cnt_q == 8'(cpm_pkg::SOFT_RESET_CYC - 1));
  wire retain = ecs_q[cpm_pkg::ECS_RETAIN_CTRL];
  wire clr_sticky = in_srst && !retain;
  wire mem_clear = !RST_N_IN || in_srst;

  // ----------------------------------------
  // mode resolution
  // ----------------------------------------
  wire neg_en = ctrl_q[cpm_pkg::BC_NEG_EN];
  wire spd_msb = ctrl_q[cpm_pkg::BC_SPEED_MSB];
  wire spd_lsb = ctrl_q[cpm_pkg::BC_SPEED_LSB];
  wire fgig_test = energy_q[cpm_pkg::EN_FGIG_TEST] && spd_lsb && !spd_msb;
  // a forced 1000 setting lands on 100; the test mode lifts only the 100 setting to 1000
  wire [1:0] forced_spd = fgig_test ? cpm_pkg::SPD_1000 :
                          spd_msb ? cpm_pkg::SPD_100 : {1'b0, spd_lsb};
  wire [1:0] neg_spd = LINK_IN.partner_neg ? LINK_IN.neg_speed : LINK_IN.par_speed;
  wire [1:0] speed_d = neg_en ? neg_spd : forced_spd;
  wire duplex_d = neg_en ? LINK_IN.neg_full_duplex : ctrl_q[cpm_pkg::BC_DUPLEX];
  wire [1:0] xsel = emode_q[cpm_pkg::EM_XOVER_SEL +: 2];
  wire auto_x = (neg_en || fgig_test || !bypass_q[cpm_pkg::BY_FSPD_XOVER_DIS]);
  wire [1:0] auto_map = bypass_q[cpm_pkg::BY_PAIR_SWAP_DISABLE] ?
                        {1'b0, LINK_IN.det_map[0]} : LINK_IN.det_map;
  wire [1:0] map_d = (xsel == cpm_pkg::XSEL_STRAIGHT) ? cpm_pkg::MAP_STRAIGHT :
                     (xsel == cpm_pkg::XSEL_CROSSED) ? cpm_pkg::MAP_CROSSED :
                     auto_x ? auto_map : cpm_pkg::MAP_STRAIGHT;
  wire [3:0] pol_d = bypass_q[cpm_pkg::BY_POL_CORR_DIS] ? 4'h0 : LINK_IN.pol_inverted;
  wire ds_en = ext3_q[cpm_pkg::E3_DS_EN];
  wire [2:0] ds_limit = 3'(ext3_q[cpm_pkg::E3_DS_CNT +: 2]) + cpm_pkg::DS_BASE_ATTEMPTS;
  wire ds_hit = ds_en && neg_en && LINK_IN.gig_attempt_fail && (fail_cnt_q + 3'h1 >= ds_limit);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [15:0] ctrl_rd = ctrl_q | (16'(in_srst) << cpm_pkg::BC_SOFT_RESET);
  wire [15:0] ext3_rd = ext3_q | (16'(down_q) << cpm_pkg::E3_DS_STAT);
  wire [15:0] aux_rd = (16'(MDI_MAP_OUT[0]) << cpm_pkg::AUX_XOVER) |
                       (16'(MDI_MAP_OUT[1]) << cpm_pkg::AUX_SWAP) |
                       (16'(POL_FIX_OUT) << cpm_pkg::AUX_POL);
  wire [15:0] reg_rdata_d = hit_ctrl ? ctrl_rd : hit_mctl ? mmd_ctl_q :
                            hit_mdat ? mmd_adr_q : hit_byp ? bypass_q :
                            hit_ext3 ? ext3_rd : hit_ecs ? ecs_q :
                            hit_emode ? emode_q : hit_aux ? aux_rd :
                            hit_page ? 16'(page_q) : hit_energy ? energy_q : 16'h0000;

  always_comb begin
    state_d = state_q;
    case (state_q)
      cpm_pkg::CPM_RUN: begin
        if (srst_start) begin
          state_d = cpm_pkg::CPM_SOFT_RESET;
        end
      end
      cpm_pkg::CPM_SOFT_RESET: begin
        if (srst_done) begin
          state_d = cpm_pkg::CPM_RUN;
        end
      end
      default: state_d = cpm_pkg::CPM_RUN;
    endcase
  end

  // ----------------------------------------
  // sequencing and non-retained fields
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN || in_srst) begin
      ctrl_q <= cpm_pkg::BASIC_CTRL_RST;
      ecs_q <= cpm_pkg::EXT_CTRL_STAT_RST;
      emode_q <= cpm_pkg::EXT_MODE_RST;
      energy_q <= cpm_pkg::ENERGY_CTRL_RST;
      mmd_ctl_q <= cpm_pkg::MMD_RST;
      mmd_adr_q <= cpm_pkg::MMD_RST;
      page_q <= cpm_pkg::PAGE_STD;
    end else if (wr_ok) begin
      if (hit_ctrl) ctrl_q <= REQ_IN.wdata & cpm_pkg::BASIC_CTRL_MASK;
      if (hit_ecs) ecs_q <= REQ_IN.wdata & cpm_pkg::ECS_MASK;
      if (hit_emode) emode_q <= REQ_IN.wdata & cpm_pkg::EXT_MODE_MASK;
      if (hit_energy) energy_q <= REQ_IN.wdata & cpm_pkg::ENERGY_MASK;
      if (hit_mctl) mmd_ctl_q <= REQ_IN.wdata;
      if (hit_mdat && mmd_addr_fn) mmd_adr_q <= REQ_IN.wdata;
      if (hit_page) page_q <= REQ_IN.wdata[1:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state_q <= cpm_pkg::CPM_RUN;
      srst_cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      srst_cnt_q <= in_srst ? srst_cnt_q + 8'h01 : 8'h00;
    end
  end

  // ----------------------------------------
  // retained fields
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN || clr_sticky) begin
      bypass_q <= cpm_pkg::BYPASS_RST;
      ext3_q <= cpm_pkg::EXT_CTRL3_RST;
    end else if (wr_ok) begin
      if (hit_byp) bypass_q <= REQ_IN.wdata & cpm_pkg::BYPASS_MASK;
      if (hit_ext3) ext3_q <= REQ_IN.wdata & cpm_pkg::EXT_CTRL3_MASK;
    end
  end

  // ----------------------------------------
  // downshift
  // ----------------------------------------
  // a gigabit partner seen while downshifted restores the advertisement, no reset needed
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN || in_srst || !ds_en || LINK_IN.gig_partner_seen) begin
      fail_cnt_q <= 3'h0;
      down_q <= 1'b0;
    end else if (ds_hit) begin
      down_q <= 1'b1;
    end else if (ds_en && neg_en && LINK_IN.gig_attempt_fail && !down_q) begin
      fail_cnt_q <= fail_cnt_q + 3'h1;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      SPEED_OUT <= cpm_pkg::SPD_10;
      FULL_DUPLEX_OUT <= 1'b0;
      ADVERTISE_GIG_OUT <= 1'b1;
      MDI_MAP_OUT <= cpm_pkg::MAP_STRAIGHT;
      POL_FIX_OUT <= 4'h0;
      rvalid_q <= 1'b0;
      mem_sel_q <= 1'b0;
      reg_rdata_q <= 16'h0000;
    end else begin
      SPEED_OUT <= speed_d;
      FULL_DUPLEX_OUT <= duplex_d;
      ADVERTISE_GIG_OUT <= !down_q;
      MDI_MAP_OUT <= map_d;
      POL_FIX_OUT <= pol_d;
      rvalid_q <= rd_ok;
      mem_sel_q <= !hit_model;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign RVALID_OUT = rvalid_q;
  assign RDATA_OUT = mem_sel_q ? mem_rdata : reg_rdata_q;

  cpm_reg_mem u_mem (
    .clk_in(CLK_IN),
    .clear_in(mem_clear),
    .wr_in(mem_wr),
    .addr_in(mem_addr),
    .wdata_in(REQ_IN.wdata),
    .rdata_out(mem_rdata)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // busy spans SOFT_RESET_CYC ticks after the start; first five are counted apart
  localparam int SRST_TAIL = cpm_pkg::SOFT_RESET_CYC - 4;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  all_addr_write_a: assert property (
    REQ_IN.valid && REQ_IN.write && !addr_match && ecs_q[cpm_pkg::ECS_ALL_ADDR_WR] &&
    !in_srst && hit_page |=> page_q == $past(REQ_IN.wdata[1:0]))
    else $error("write with foreign address not taken");
  read_addr_gate_a: assert property (
    REQ_IN.valid && !REQ_IN.write && !addr_match |=> !RVALID_OUT)
    else $error("read answered for foreign address");
  soft_reset_len_a: assert property (
    srst_start |=> in_srst [*5] ##SRST_TAIL !in_srst)
    else $error("soft reset length wrong");
  soft_reset_defaults_a: assert property (
    in_srst |=> ctrl_q == cpm_pkg::BASIC_CTRL_RST && page_q == cpm_pkg::PAGE_STD)
    else $error("non-retained field not restored");
  retained_keep_a: assert property (
    in_srst && retain |=> $stable(bypass_q) && $stable(ext3_q))
    else $error("retained field lost");
  forced_speed_a: assert property (
    !neg_en && !fgig_test |=> SPEED_OUT == $past(forced_spd) && SPEED_OUT != cpm_pkg::SPD_1000)
    else $error("forced speed wrong");
  gig_test_a: assert property (
    !neg_en && fgig_test |=> SPEED_OUT == cpm_pkg::SPD_1000)
    else $error("forced gigabit test not applied");
  manual_xover_a: assert property (
    xsel == cpm_pkg::XSEL_CROSSED |=> MDI_MAP_OUT == cpm_pkg::MAP_CROSSED)
    else $error("manual crossed select ignored");
  pol_disable_a: assert property (
    bypass_q[cpm_pkg::BY_POL_CORR_DIS] |=> POL_FIX_OUT == 4'h0)
    else $error("polarity fixed while disabled");
  downshift_a: assert property (
    ds_hit && !in_srst && !LINK_IN.gig_partner_seen |=> down_q ##1 !ADVERTISE_GIG_OUT)
    else $error("downshift not applied");

  soft_reset_c: cover property (srst_start ##[1:40] !in_srst);
  downshift_c: cover property (ds_hit ##[1:20] LINK_IN.gig_partner_seen);
  mmd_read_c: cover property (rd_ok && hit_mdat && !mmd_addr_fn ##1 RVALID_OUT);
endmodule // cpm_mgmt_cfg

// File: testbench/cpm_mgmt_host.sv
// management controller model: one register request at a time on the request word
// assumes the bench calls its tasks from a single process; drives after falling edges
`timescale 1ns/10ps
module cpm_mgmt_host (
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [15:0] rdata_in,
  output cpm_pkg::cpm_req_s req_out
);
  initial req_out = '0;
  // ----------------------------------------
  // request cycles
  // ----------------------------------------
  // idle word carries inverted fields so a stale decode cannot look valid
  task automatic send(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd);
    @(negedge clk_in);
    req_out <= {1'b1, wr, pa, ra, wd};
    @(negedge clk_in);
    req_out <= {1'b0, ~wr, ~pa, ~ra, ~wd};
  endtask
  // no answer within three falling edges counts as refused
  task automatic read(input logic [4:0] pa, input logic [4:0] ra, output logic [15:0] rd,
                      output bit got);
    got = 1'b0;
    rd = 16'h0000;
    send(1'b0, pa, ra, 16'h0000);
    for (int i = 0; i < 3 && !got; i++) begin
      if (rvalid_in === 1'b1) begin
        got = 1'b1;
        rd = rdata_in;
      end else begin
        @(negedge clk_in);
      end
    end
  endtask
  // paged words are only touched after the page field is set
  task automatic page(input logic [4:0] pa, input logic [1:0] pg);
    send(1'b1, pa, cpm_pkg::REG_PAGE_SEL, {14'h0000, pg});
  endtask
endmodule // cpm_mgmt_host

// File: testbench/cpm_mgmt_cfg_bench.sv
// self-checking bench for the management register bank
// assumes the host model drives requests; link inputs change at falling edges
`timescale 1ns/10ps
module cpm_mgmt_cfg_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] own = 5'h05;
  cpm_pkg::cpm_req_s req;
  cpm_pkg::cpm_link_s link = '0;
  logic rvalid, fdx, adv;
  logic [15:0] rdata, rd, d;
  logic [1:0] speed, map, pg;
  logic [4:0] ra;
  logic [3:0] pol;
  bit got;
  int fail_count = 0;
  int total_checks = 0;
  int mem[int];
  logic [15:0] ctl_v [4] = '{16'h0000, 16'h2100, 16'h0040, 16'h2000};
  logic [1:0] spd_v [4] = '{cpm_pkg::SPD_10, cpm_pkg::SPD_100, cpm_pkg::SPD_100,
                            cpm_pkg::SPD_1000};
  always #2 clk = ~clk;
  cpm_mgmt_cfg u_cpm_mgmt_cfg (.CLK_IN(clk), .RST_N_IN(rst_n), .PHY_ADDR_IN(own),
    .REQ_IN(req), .LINK_IN(link), .RVALID_OUT(rvalid), .RDATA_OUT(rdata),
    .SPEED_OUT(speed), .FULL_DUPLEX_OUT(fdx), .ADVERTISE_GIG_OUT(adv),
    .MDI_MAP_OUT(map), .POL_FIX_OUT(pol));
  cpm_mgmt_host u_cpm_mgmt_host (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata),
    .req_out(req));
  // ----------------------------------------
  // compares and helpers
  // ----------------------------------------
  task automatic chk_rd(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_out(input string n, input logic [3:0] e, input logic [3:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    u_cpm_mgmt_host.send(1'b1, own, a, v);
  endtask
  task automatic rdchk(input string n, input logic [4:0] a, input logic [15:0] m,
                       input logic [15:0] e);
    u_cpm_mgmt_host.read(own, a, rd, got);
    chk_out({n, " answer"}, 4'h1, {3'h0, got});
    chk_rd(n, e & m, rd & m);
  endtask
  // mode outputs are levels one edge behind their cause; three edges is margin
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  task automatic hw_reset;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic soft_reset;
    wr(cpm_pkg::REG_BASIC_CTRL, 16'h9140);
    rdchk("busy", cpm_pkg::REG_BASIC_CTRL, 16'h8000, 16'h8000);
    for (int i = 0; i < 20 && rd[15] !== 1'b0; i++) begin
      u_cpm_mgmt_host.read(own, cpm_pkg::REG_BASIC_CTRL, rd, got);
    end
    chk_out("self clear", 4'h0, {3'h0, rd[15]});
  endtask
  task automatic pulse_fail;
    @(negedge clk);
    link.gig_attempt_fail = 1'b1;
    @(negedge clk);
    link.gig_attempt_fail = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("FAIL watchdog expected finish seen hang");
    complete_run();
  end
  initial begin
    void'($urandom(85347));
    hw_reset();
    rdchk("ctrl", cpm_pkg::REG_BASIC_CTRL, 16'hFFFF, cpm_pkg::BASIC_CTRL_RST);
    rdchk("page", cpm_pkg::REG_PAGE_SEL, 16'h0003, 16'h0000);
    rdchk("bypass", cpm_pkg::REG_BYPASS, 16'h00B0, cpm_pkg::BYPASS_RST);
    chk_out("adv", 4'h1, {3'h0, adv});
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      pg = i[0] ? cpm_pkg::PAGE_GP : cpm_pkg::PAGE_EXT1;
      ra = i[0] ? 5'($urandom % 31) : 5'h10 + 5'($urandom % 15);
      d = 16'($urandom);
      u_cpm_mgmt_host.page(own, pg);
      wr(ra, d);
      mem[int'({pg, ra})] = int'(d);
    end
    foreach (mem[k]) begin
      u_cpm_mgmt_host.page(own, 2'(k >> 5));
      rdchk("paged", 5'(k), 16'hFFFF, 16'(mem[k]));
    end
    $display("test paged spaces done");
    u_cpm_mgmt_host.page(own, cpm_pkg::PAGE_EXT1);
    wr(5'h10, 16'h00FF);
    u_cpm_mgmt_host.send(1'b1, ~own, 5'h10, 16'h1234);
    rdchk("foreign refused", 5'h10, 16'hFFFF, 16'h00FF);
    u_cpm_mgmt_host.page(own, cpm_pkg::PAGE_STD);
    wr(cpm_pkg::REG_EXT_CTRL_STAT, 16'h3000);
    u_cpm_mgmt_host.page(~own, cpm_pkg::PAGE_EXT1);
    u_cpm_mgmt_host.send(1'b1, ~own, 5'h10, 16'h1234);
    rdchk("all address", 5'h10, 16'hFFFF, 16'h1234);
    u_cpm_mgmt_host.read(~own, 5'h10, rd, got);
    chk_out("foreign read", 4'h0, {3'h0, got});
    u_cpm_mgmt_host.page(own, cpm_pkg::PAGE_STD);
    wr(cpm_pkg::REG_EXT_CTRL_STAT, 16'h1000);
    $display("test address filter done");
    wr(cpm_pkg::REG_MMD_CTRL, 16'h0003);
    wr(cpm_pkg::REG_MMD_DATA, 16'h0005);
    wr(cpm_pkg::REG_MMD_CTRL, 16'h4003);
    wr(cpm_pkg::REG_MMD_DATA, 16'hA5C3);
    rdchk("c45 word", cpm_pkg::REG_MMD_DATA, 16'hFFFF, 16'hA5C3);
    wr(cpm_pkg::REG_MMD_CTRL, 16'h0003);
    wr(cpm_pkg::REG_MMD_DATA, 16'h0006);
    wr(cpm_pkg::REG_MMD_CTRL, 16'h4003);
    rdchk("c45 other", cpm_pkg::REG_MMD_DATA, 16'hFFFF, 16'h0000);
    $display("test indirect words done");
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        u_cpm_mgmt_host.page(own, cpm_pkg::PAGE_EXT2);
        wr(cpm_pkg::REG_ENERGY_CTRL, 16'h8000);
        u_cpm_mgmt_host.page(own, cpm_pkg::PAGE_STD);
      end
      wr(cpm_pkg::REG_BASIC_CTRL, ctl_v[i]);
      settle();
      chk_out("speed", {2'h0, spd_v[i]}, {2'h0, speed});
      chk_out("duplex", {3'h0, ctl_v[i][8]}, {3'h0, fdx});
    end
    u_cpm_mgmt_host.page(own, cpm_pkg::PAGE_EXT2);
    wr(cpm_pkg::REG_ENERGY_CTRL, 16'h0000);
    u_cpm_mgmt_host.page(own, cpm_pkg::PAGE_STD);
    $display("test forced speed done");
    for (int m = 0; m < 4; m++) begin
      link.det_map = 2'(m);
      settle();
      chk_out("forced map", 4'(m), {2'h0, map});
    end
    wr(cpm_pkg::REG_BYPASS, 16'h0080);
    settle();
    chk_out("forced map off", 4'h0, {2'h0, map});
    wr(cpm_pkg::REG_BYPASS, 16'h0000);
    wr(cpm_pkg::REG_EXT_MODE, 16'h0008);
    settle();
    chk_out("manual straight", {2'h0, cpm_pkg::MAP_STRAIGHT}, {2'h0, map});
    wr(cpm_pkg::REG_EXT_MODE, 16'h000C);
    link.det_map = 2'h0;
    settle();
    chk_out("manual crossed", {2'h0, cpm_pkg::MAP_CROSSED}, {2'h0, map});
    wr(cpm_pkg::REG_EXT_MODE, 16'h0000);
    link.det_map = 2'h2;
    link.pol_inverted = 4'($urandom) | 4'h1;
    settle();
    chk_out("pol fix", link.pol_inverted, pol);
    rdchk("aux", cpm_pkg::REG_AUX_STAT, 16'h3F00,
          {2'h0, link.det_map[0], link.det_map[1], link.pol_inverted, 8'h00});
    wr(cpm_pkg::REG_BYPASS, 16'h0010);
    settle();
    chk_out("pol off", 4'h0, pol);
    wr(cpm_pkg::REG_BYPASS, 16'h0000);
    $display("test crossover polarity done");
    wr(cpm_pkg::REG_BASIC_CTRL, 16'h1140);
    link.partner_neg = 1'b1;
    link.neg_speed = cpm_pkg::SPD_1000;
    link.neg_full_duplex = 1'b1;
    settle();
    chk_out("neg speed", {2'h0, cpm_pkg::SPD_1000}, {2'h0, speed});
    chk_out("neg duplex", 4'h1, {3'h0, fdx});
    link.partner_neg = 1'b0;
    link.par_speed = cpm_pkg::SPD_100;
    settle();
    chk_out("parallel speed", {2'h0, cpm_pkg::SPD_100}, {2'h0, speed});
    wr(cpm_pkg::REG_EXT_CTRL3, 16'h0014);
    for (int i = 0; i < 3; i++) begin
      pulse_fail();
      settle();
      chk_out("downshift", {3'h0, i < 2}, {3'h0, adv});
    end
    rdchk("ds status", cpm_pkg::REG_EXT_CTRL3, 16'h0002, 16'h0002);
    link.gig_partner_seen = 1'b1;
    @(negedge clk);
    link.gig_partner_seen = 1'b0;
    settle();
    chk_out("resume gig", 4'h1, {3'h0, adv});
    $display("test negotiation downshift done");
    wr(cpm_pkg::REG_BYPASS, 16'h00B0);
    wr(cpm_pkg::REG_EXT_MODE, 16'h000C);
    soft_reset();
    rdchk("ctrl back", cpm_pkg::REG_BASIC_CTRL, 16'hFFFF, cpm_pkg::BASIC_CTRL_RST);
    rdchk("mode back", cpm_pkg::REG_EXT_MODE, 16'h000C, 16'h0000);
    rdchk("bypass kept", cpm_pkg::REG_BYPASS, 16'h00B0, 16'h00B0);
    rdchk("ds kept", cpm_pkg::REG_EXT_CTRL3, 16'h001C, 16'h0014);
    wr(cpm_pkg::REG_EXT_CTRL_STAT, 16'h0000);
    soft_reset();
    rdchk("bypass wiped", cpm_pkg::REG_BYPASS, 16'h00B0, 16'h0000);
    $display("test soft reset done");
    wr(cpm_pkg::REG_BYPASS, 16'h0090);
    wr(cpm_pkg::REG_EXT_CTRL_STAT, 16'h3000);
    hw_reset();
    rdchk("hw bypass", cpm_pkg::REG_BYPASS, 16'hFFFF, cpm_pkg::BYPASS_RST);
    rdchk("hw ecs", cpm_pkg::REG_EXT_CTRL_STAT, 16'hFFFF, cpm_pkg::EXT_CTRL_STAT_RST);
    $display("test hardware reset done");
    complete_run();
  end
endmodule // cpm_mgmt_cfg_bench
